// File: logic/tws_pkg.sv
// Constants, types and register map of the three-wire serial unit.
// ****************************************************************
// Functional notes
// - In single-byte mode a write to the shift register starts one byte.
// - After completion with the active flag clear, the shift register holds received data.
// - Unit disabled: stop, data output low, clock pin high, internal reset.
// - Disabling clears address counter, trigger, shift register and active flag.
// - While the unit is disabled the buffer RAM cannot be accessed.
// - Buffer RAM contents need not survive a disable and re-enable.
// - Mode bit 6 selects single-byte (0) or automatic buffer (1) transfer.
// - Repeat select: 0 stops at the end address, 1 wraps the counter to 00H.
// - Clock source select: 0 slave on external clock, 1 master on internal.
// - Transmit disabled holds the serial data output low.
// - Receive enable bit disables (0) or enables (1) reception.
// - Base clock is the peripheral clock (0) or half of it (1).
// - Active flag is 1 from start to end; 0 after reset, disable, end or stop.
// - The trigger register accepts writes only while automatic mode is selected.
// - Automatic start or stop takes effect only after the current byte ends.
// - Stop and start request bits clear by hardware at the completion event.
// - After a stop the counter keeps its position; restart needs a new start request.
// - Completion is raised once the inter-byte interval has elapsed after a byte; as slave the code raises it at once.
// - Bit order of each byte is selectable, most or least significant first.
// ****************************************************************
package tws_pkg;

    // ****************************************************************
    // Register indices; the APB byte address is four times the index.
    // ****************************************************************
    localparam logic [15:0] IDX_MODE = 16'hFF90;
    localparam logic [15:0] IDX_STATUS = 16'hFF91;
    localparam logic [15:0] IDX_TRIGGER = 16'hFF92;
    localparam logic [15:0] IDX_SHIFT = 16'hFF96;
    localparam logic [15:0] IDX_AUTOCFG = 16'hFF98;
    localparam int APB_ADDR_W = 18;

    // Reset values and field positions.
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [1:0] TRIGGER_RESET = 2'h0;
    localparam logic [7:0] SHIFT_RESET = 8'h00;
    localparam int STAT_BSEL_BIT = 6;
    localparam int TRIG_STOP_BIT = 1;
    localparam int TRIG_START_BIT = 0;
    localparam int CFG_END_LSB = 0;
    localparam int CFG_IVAL_LSB = 8;
    localparam int CFG_ADDR_LSB = 16;
    localparam int BYTE_BITS = 8;
    localparam int HALF_DIV_DEFAULT = 4;

    // Mode control register, bit 7 down to bit 0.
    typedef struct packed {
        logic unit_enable;
        logic automatic_mode_select;
        logic repeat_select;
        logic clock_source_select;
        logic transmit_enable;
        logic receive_enable;
        logic first_bit_select;
        logic zero;
    } tws_mode_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [APB_ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } tws_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } tws_apb_rsp_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SHIFT = 3'b010,
        ST_GAP = 3'b100
    } tws_state_t;

endpackage

// File: logic/tws_serial_unit.sv
// Three-wire serial unit: APB registers, shift engine, pins and assertions.
//
// Our own choice: register access over APB.
`timescale 1ns/10ps
module tws_serial_unit #(
    parameter int HALF_DIV = tws_pkg::HALF_DIV_DEFAULT
)(
    input wire logic core_clk,
    input wire logic rstn,
    input wire tws_pkg::tws_apb_req_t apb_req,
    output tws_pkg::tws_apb_rsp_t apb_rsp,
    input wire logic serial_clock_in,
    output logic serial_clock_out,
    output logic serial_clock_oe,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic completion_interrupt,
    output logic [4:0] transfer_address_counter,
    output logic buffer_access_enable
);

    // ****************************************************************
    // Elaboration checks.
    // ****************************************************************
    if (HALF_DIV < 1 || HALF_DIV > 256)
    begin : g_bad_div
        $error("HALF_DIV must lie between 1 and 256");
    end

    localparam int HC_W = $clog2(HALF_DIV + 1);
    localparam int GAP_W = 6 + $clog2(2 * HALF_DIV) + 1;
    localparam logic [HC_W-1:0] HC_LAST = HC_W'(HALF_DIV - 1);
    localparam logic [GAP_W-1:0] PERIOD = GAP_W'(2 * HALF_DIV);

    // ****************************************************************
    // Declarations.
    // ****************************************************************
    tws_pkg::tws_apb_rsp_t rsp_reg;
    tws_pkg::tws_mode_t mode_reg;
    tws_pkg::tws_state_t state_reg;
    logic bsel_reg;
    logic [1:0] trig_reg;
    logic [4:0] end_reg;
    logic [5:0] ival_reg;
    logic [7:0] sr_reg;
    logic [3:0] bit_reg;
    logic [HC_W-1:0] hc_reg;
    logic [GAP_W-1:0] gap_reg;
    logic [4:0] addr_reg;
    logic active_reg;
    logic sck_reg;
    logic sck_oe_reg;
    logic sdo_reg;
    logic irq_reg;
    logic bufen_reg;
    logic half_reg;
    logic [2:0] sck_sync_reg;
    logic [2:0] sdi_sync_reg;
    logic sck_filt_reg;
    logic sdi_filt_reg;
    logic setup;
    logic wr_acc;
    logic wr_mode;
    logic wr_stat;
    logic wr_trig;
    logic wr_shift;
    logic wr_cfg;
    logic tick;
    logic s_fall;
    logic s_rise;
    logic ev_fall;
    logic ev_rise;
    logic start_single;
    logic start_auto;
    logic byte_done;
    logic auto_end;
    logic in_bit;
    logic sdi_now;
    logic [7:0] sr_shifted;
    logic [GAP_W-1:0] gap_target;
    logic [7:0] wdata8;

    // ****************************************************************
    // APB slave.
    // ****************************************************************

    // Decode write strobes; a write lands only on the access edge with pready high.
    assign setup = apb_req.psel & ~apb_req.penable;
    assign wr_acc = apb_req.psel & apb_req.penable & apb_req.pwrite & rsp_reg.pready;
    assign wdata8 = apb_req.pwdata[7:0];
    assign wr_mode = wr_acc && apb_req.paddr == {tws_pkg::IDX_MODE, 2'b00};
    assign wr_stat = wr_acc && apb_req.paddr == {tws_pkg::IDX_STATUS, 2'b00};
    assign wr_trig = wr_acc && apb_req.paddr == {tws_pkg::IDX_TRIGGER, 2'b00};
    assign wr_shift = wr_acc && apb_req.paddr == {tws_pkg::IDX_SHIFT, 2'b00};
    assign wr_cfg = wr_acc && apb_req.paddr == {tws_pkg::IDX_AUTOCFG, 2'b00};

    // Answer one cycle after setup: read data is captured in the setup cycle,
    // so every transfer has exactly one access cycle and no wait states.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rsp_reg <= '0;
        end
        else if (setup)
        begin
            rsp_reg.pready <= 1'b1;
            rsp_reg.pslverr <= 1'b0;
            unique case (apb_req.paddr)
                {tws_pkg::IDX_MODE, 2'b00}: rsp_reg.prdata <= {24'h000000, mode_reg};
                {tws_pkg::IDX_STATUS, 2'b00}: rsp_reg.prdata <=
                    {24'h000000, 1'b0, bsel_reg, 5'h00, active_reg};
                {tws_pkg::IDX_TRIGGER, 2'b00}: rsp_reg.prdata <= {30'h00000000, trig_reg};
                {tws_pkg::IDX_SHIFT, 2'b00}: rsp_reg.prdata <= {24'h000000, sr_reg};
                {tws_pkg::IDX_AUTOCFG, 2'b00}: rsp_reg.prdata <=
                    {11'h000, addr_reg, 2'h0, ival_reg, 3'h0, end_reg};
                default:
                begin
                    rsp_reg.prdata <= 32'h00000000;
                    rsp_reg.pslverr <= 1'b1;
                end
            endcase
        end
        else
        begin
            rsp_reg.pready <= 1'b0;
            rsp_reg.pslverr <= 1'b0;
        end
    end

    // Mode control register; bit 0 always reads zero.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mode_reg <= tws_pkg::MODE_RESET;
        end
        else if (wr_mode)
        begin
            mode_reg <= {wdata8[7:1], 1'b0};
        end
    end

    // Base clock select and own automatic-transfer settings.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            bsel_reg <= tws_pkg::STATUS_RESET[tws_pkg::STAT_BSEL_BIT];
            end_reg <= 5'h00;
            ival_reg <= 6'h00;
        end
        else
        begin
            if (wr_stat)
            begin
                bsel_reg <= wdata8[tws_pkg::STAT_BSEL_BIT];
            end
            if (wr_cfg)
            begin
                end_reg <= apb_req.pwdata[tws_pkg::CFG_END_LSB +: 5];
                ival_reg <= apb_req.pwdata[tws_pkg::CFG_IVAL_LSB +: 6];
            end
        end
    end

    // Trigger register. A software write wins over the hardware clear so a
    // request made in the completion cycle is not lost.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            trig_reg <= tws_pkg::TRIGGER_RESET;
        end
        else if (!mode_reg.unit_enable)
        begin
            trig_reg <= tws_pkg::TRIGGER_RESET;
        end
        else if (wr_trig && mode_reg.automatic_mode_select)
        begin
            trig_reg <= wdata8[1:0];
        end
        else if (byte_done)
        begin
            trig_reg <= tws_pkg::TRIGGER_RESET;
        end
    end

    // ****************************************************************
    // Pin synchronisers and base clock.
    // ****************************************************************

    // Three flops per pin; a new level counts once the second and third agree.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sck_sync_reg <= 3'h7;
            sdi_sync_reg <= 3'h0;
            sck_filt_reg <= 1'b1;
            sdi_filt_reg <= 1'b0;
        end
        else
        begin
            sck_sync_reg <= {sck_sync_reg[1:0], serial_clock_in};
            sdi_sync_reg <= {sdi_sync_reg[1:0], serial_data_in};
            if (sck_sync_reg[1] == sck_sync_reg[2])
            begin
                sck_filt_reg <= sck_sync_reg[2];
            end
            if (sdi_sync_reg[1] == sdi_sync_reg[2])
            begin
                sdi_filt_reg <= sdi_sync_reg[2];
            end
        end
    end

    assign s_fall = sck_filt_reg & (sck_sync_reg[1] == sck_sync_reg[2]) & ~sck_sync_reg[2];
    assign s_rise = ~sck_filt_reg & (sck_sync_reg[1] == sck_sync_reg[2]) & sck_sync_reg[2];

    // Half-rate enable; with base select at 1 the master divider and gap counter advance every other cycle.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            half_reg <= 1'b0;
        end
        else
        begin
            half_reg <= ~half_reg;
        end
    end

    assign tick = ~bsel_reg | half_reg;

    // ****************************************************************
    // Shift engine.
    // ****************************************************************

    // Edge source: internal divider as master, the filtered pin as slave.
    assign ev_fall = mode_reg.clock_source_select ?
        (tick && hc_reg == HC_LAST && sck_reg) : s_fall;
    assign ev_rise = mode_reg.clock_source_select ?
        (tick && hc_reg == HC_LAST && !sck_reg) : s_rise;

    // Received bit is zero while reception is off. The data pin counts on the edge at
    // which its second and third flops agree, a cycle ahead of the filtered copy, so a
    // peer that changes data on the falling clock still meets a four-tick half period.
    assign sdi_now = (sdi_sync_reg[1] == sdi_sync_reg[2]) ? sdi_sync_reg[2] : sdi_filt_reg;
    assign in_bit = mode_reg.receive_enable & sdi_now;
    assign sr_shifted = mode_reg.first_bit_select ?
        {in_bit, sr_reg[7:1]} : {sr_reg[6:0], in_bit};

    // The inter-byte gap only applies as master; a slave finishes at once.
    assign gap_target = mode_reg.clock_source_select ?
        GAP_W'(ival_reg) * PERIOD : '0;
    assign byte_done = state_reg == tws_pkg::ST_GAP && gap_reg >= gap_target;
    assign auto_end = trig_reg[tws_pkg::TRIG_STOP_BIT]
        || (addr_reg == end_reg && !mode_reg.repeat_select);

    // Single mode starts on a shift write; automatic mode on the start bit.
    assign start_single = wr_shift && !active_reg
        && !mode_reg.automatic_mode_select;
    assign start_auto = mode_reg.automatic_mode_select
        && trig_reg[tws_pkg::TRIG_START_BIT] && !active_reg;

    // Disable acts as a clear on the next edge rather than a true asynchronous
    // reset, so no register reset is ever derived from logic.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= tws_pkg::ST_IDLE;
            sr_reg <= tws_pkg::SHIFT_RESET;
            bit_reg <= 4'h0;
            hc_reg <= '0;
            gap_reg <= '0;
            addr_reg <= 5'h00;
            active_reg <= 1'b0;
            sck_reg <= 1'b1;
            sdo_reg <= 1'b0;
            irq_reg <= 1'b0;
        end
        else if (!mode_reg.unit_enable)
        begin
            state_reg <= tws_pkg::ST_IDLE;
            sr_reg <= tws_pkg::SHIFT_RESET;
            bit_reg <= 4'h0;
            hc_reg <= '0;
            gap_reg <= '0;
            addr_reg <= 5'h00;
            active_reg <= 1'b0;
            sck_reg <= 1'b1;
            sdo_reg <= 1'b0;
            irq_reg <= 1'b0;
        end
        else
        begin
            irq_reg <= 1'b0;
            unique case (state_reg)
                tws_pkg::ST_IDLE:
                begin
                    bit_reg <= 4'h0;
                    hc_reg <= '0;
                    sck_reg <= 1'b1;
                    if (start_single)
                    begin
                        sr_reg <= wdata8;
                        active_reg <= 1'b1;
                        state_reg <= tws_pkg::ST_SHIFT;
                        sdo_reg <= mode_reg.first_bit_select ? wdata8[0] : wdata8[7];
                    end
                    else if (start_auto)
                    begin
                        addr_reg <= 5'h00;
                        active_reg <= 1'b1;
                        state_reg <= tws_pkg::ST_SHIFT;
                        sdo_reg <= mode_reg.first_bit_select ? sr_reg[0] : sr_reg[7];
                    end
                end
                tws_pkg::ST_SHIFT:
                begin
                    // Master divider; a stop request is not looked at here.
                    if (mode_reg.clock_source_select && tick)
                    begin
                        hc_reg <= (hc_reg == HC_LAST) ? '0 : hc_reg + 1'b1;
                        if (hc_reg == HC_LAST)
                        begin
                            sck_reg <= ~sck_reg;
                        end
                    end
                    if (ev_fall && bit_reg != 4'h0)
                    begin
                        sdo_reg <= mode_reg.first_bit_select ? sr_reg[0] : sr_reg[7];
                    end
                    if (ev_rise)
                    begin
                        sr_reg <= sr_shifted;
                        bit_reg <= bit_reg + 1'b1;
                        if (bit_reg == 4'(tws_pkg::BYTE_BITS - 1))
                        begin
                            state_reg <= tws_pkg::ST_GAP;
                            gap_reg <= '0;
                        end
                    end
                end
                tws_pkg::ST_GAP:
                begin
                    sck_reg <= 1'b1;
                    if (byte_done)
                    begin
                        irq_reg <= 1'b1;
                        bit_reg <= 4'h0;
                        hc_reg <= '0;
                        if (!mode_reg.automatic_mode_select || auto_end)
                        begin
                            // Stop keeps the counter where it stopped.
                            active_reg <= 1'b0;
                            state_reg <= tws_pkg::ST_IDLE;
                        end
                        else
                        begin
                            addr_reg <= (addr_reg == end_reg) ? 5'h00 : addr_reg + 1'b1;
                            state_reg <= tws_pkg::ST_SHIFT;
                            sdo_reg <= mode_reg.first_bit_select ? sr_reg[0] : sr_reg[7];
                        end
                    end
                    else if (tick)
                    begin
                        gap_reg <= gap_reg + 1'b1;
                    end
                end
            endcase
            if (!mode_reg.clock_source_select)
            begin
                sck_reg <= 1'b1;
            end
            if (!mode_reg.transmit_enable)
            begin
                sdo_reg <= 1'b0;
            end
        end
    end

    // Clock pin is driven as master, and held high while the unit is off.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sck_oe_reg <= 1'b1;
            bufen_reg <= 1'b0;
        end
        else
        begin
            sck_oe_reg <= ~mode_reg.unit_enable | mode_reg.clock_source_select;
            bufen_reg <= mode_reg.unit_enable;
        end
    end

    assign apb_rsp = rsp_reg;
    assign serial_clock_out = sck_reg;
    assign serial_clock_oe = sck_oe_reg;
    assign serial_data_out = sdo_reg;
    assign completion_interrupt = irq_reg;
    assign transfer_address_counter = addr_reg;
    assign buffer_access_enable = bufen_reg;

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    property p_single_start;
        start_single && mode_reg.unit_enable && state_reg == tws_pkg::ST_IDLE
            |=> active_reg && state_reg == tws_pkg::ST_SHIFT;
    endproperty
    a_single_start: assert property (p_single_start) else $error("single start lost");

    property p_disable_pins;
        !mode_reg.unit_enable |=> !serial_data_out && serial_clock_out && serial_clock_oe;
    endproperty
    a_disable_pins: assert property (p_disable_pins) else $error("pins wrong when off");

    property p_disable_clear;
        !mode_reg.unit_enable |=> !active_reg && trig_reg == 2'h0 && addr_reg == 5'h00
            && sr_reg == 8'h00;
    endproperty
    a_disable_clear: assert property (p_disable_clear) else $error("state kept when off");

    property p_trig_gate;
        wr_trig && !mode_reg.automatic_mode_select && mode_reg.unit_enable && !byte_done
            |=> $stable(trig_reg);
    endproperty
    a_trig_gate: assert property (p_trig_gate) else $error("trigger written in single mode");

    property p_tx_off;
        mode_reg.unit_enable && !mode_reg.transmit_enable |=> !serial_data_out;
    endproperty
    a_tx_off: assert property (p_tx_off) else $error("data out not low");

    property p_slave_clock;
        mode_reg.unit_enable && !mode_reg.clock_source_select && $stable(mode_reg)
            |=> !serial_clock_oe;
    endproperty
    a_slave_clock: assert property (p_slave_clock) else $error("slave drives clock");

    property p_req_clear;
        completion_interrupt && !$past(wr_trig) |-> trig_reg == 2'h0;
    endproperty
    a_req_clear: assert property (p_req_clear) else $error("request not cleared");

    property p_flag_fall;
        $fell(active_reg) |-> $past(byte_done) || !$past(mode_reg.unit_enable);
    endproperty
    a_flag_fall: assert property (p_flag_fall) else $error("active flag fell early");

    property p_byte_holds;
        active_reg && state_reg == tws_pkg::ST_SHIFT && mode_reg.unit_enable
            |=> active_reg || !$past(mode_reg.unit_enable);
    endproperty
    a_byte_holds: assert property (p_byte_holds) else $error("stop inside a byte");

    property p_half_clock;
        bsel_reg && tick |=> !tick || !bsel_reg;
    endproperty
    a_half_clock: assert property (p_half_clock) else $error("half clock ticks twice");

    property p_done_read;
        completion_interrupt && !mode_reg.automatic_mode_select |-> !active_reg;
    endproperty
    a_done_read: assert property (p_done_read) else $error("flag set at completion");

endmodule

// File: verif/tws_peer.sv
// Behavioural serial peripheral that faces the unit on the clock and data pins.
`timescale 1ns/10ps
module tws_peer (
    input wire logic rstn,
    input wire logic sck,
    input wire logic sdo,
    input wire logic [7:0] tx_byte,
    output logic sdi,
    output logic [7:0] rx_byte
);
    logic [7:0] sh;
    int cnt;
    // Present the next bit after each falling edge, most significant first.
    always @(negedge sck)
    begin
        if (rstn)
        begin
            if (cnt == 0)
                sh = tx_byte;
            sdi <= sh[7];
            sh = {sh[6:0], 1'b0};
        end
    end
    // Capture on each rise; after the eighth the line flips so stale data never matches.
    always @(posedge sck or negedge rstn)
    begin
        if (!rstn)
            cnt = 0;
        else
        begin
            rx_byte <= {rx_byte[6:0], sdo};
            cnt = (cnt == 7) ? 0 : cnt + 1;
            if (cnt == 0)
                sdi <= ~sdi;
        end
    end
endmodule

// File: verif/testbench.sv
// Self-checking bench for the three-wire serial unit with a peripheral model.
`timescale 1ns/10ps
module testbench;
    localparam logic [17:0] A_MODE = {tws_pkg::IDX_MODE, 2'b00};
    localparam logic [17:0] A_STAT = {tws_pkg::IDX_STATUS, 2'b00};
    localparam logic [17:0] A_TRIG = {tws_pkg::IDX_TRIGGER, 2'b00};
    localparam logic [17:0] A_SHIFT = {tws_pkg::IDX_SHIFT, 2'b00};
    localparam logic [17:0] A_CFG = {tws_pkg::IDX_AUTOCFG, 2'b00};
    logic core_clk, rstn, slv_clk, pin_clk, clk_out, clk_oe, sdi, sdo, irq, bae, err;
    tws_pkg::tws_apb_req_t apb_req;
    tws_pkg::tws_apb_rsp_t apb_rsp;
    logic [7:0] peer_tx, peer_rx, tx;
    logic [31:0] rd, md;
    logic [4:0] adc;
    int bad_count, checks, cyc, seed;
    // The pin follows the unit when it drives, otherwise the bench's slave clock.
    assign pin_clk = clk_oe ? clk_out : slv_clk;
    tws_serial_unit #(.HALF_DIV(4)) dut_u (.core_clk(core_clk), .rstn(rstn),
        .apb_req(apb_req), .apb_rsp(apb_rsp), .serial_clock_in(pin_clk),
        .serial_clock_out(clk_out), .serial_clock_oe(clk_oe), .serial_data_in(sdi),
        .serial_data_out(sdo), .completion_interrupt(irq),
        .transfer_address_counter(adc), .buffer_access_enable(bae));
    tws_peer peer_u (.rstn(rstn), .sck(pin_clk), .sdo(sdo), .tx_byte(peer_tx),
        .sdi(sdi), .rx_byte(peer_rx));
    // Core clock at 125 MHz.
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task wrap_up;
        if (bad_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One APB transfer; an idle cycle after release keeps drives one per step.
    task apb(input logic w, input logic [17:0] a, input logic [31:0] d);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge core_clk);
        apb_req.penable <= 1'b1;
        do @(posedge core_clk); while (apb_rsp.pready !== 1'b1);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req <= '0;
        @(posedge core_clk);
    endtask
    function automatic logic [7:0] rev8(input logic [7:0] v);
        for (int i = 0; i < 8; i++)
            rev8[i] = v[7 - i];
    endfunction
    // Hang guard: a run far past its expected length counts as a failure.
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            bad_count++;
            wrap_up;
        end
    end
    // Main sequence: reset values, refusals, three single-byte transfers, an automatic run, then disable.
    initial
    begin
        seed = 32'h9fab;
        {rstn, slv_clk, apb_req, peer_tx, bad_count, checks, cyc} = '0;
        slv_clk = 1'b1;
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        apb(1'b0, A_MODE, 32'h0);
        chk("mode", rd, 32'h0);
        apb(1'b0, A_STAT, 32'h0);
        chk("status", rd, 32'h0);
        apb(1'b0, 18'h00000, 32'h0);
        chk("unmapped", {31'h0, err}, 32'h1);
        chk("idle pins", {29'h0, clk_oe, clk_out, sdo}, 32'h6);
        apb(1'b1, A_STAT, 32'h40);
        apb(1'b0, A_STAT, 32'h0);
        chk("base clock", rd, 32'h40);
        apb(1'b1, A_STAT, 32'h0);
        apb(1'b1, A_MODE, 32'h80);
        apb(1'b1, A_TRIG, 32'h1);
        apb(1'b0, A_TRIG, 32'h0);
        chk("trigger", rd, 32'h0);
        for (int m = 0; m < 3; m++)
        begin
            tx = 8'($random(seed));
            peer_tx <= 8'($random(seed));
            md = 32'h84 | (m < 2 ? 32'h18 : 32'h0) | (m == 1 ? 32'h2 : 32'h0);
            apb(1'b1, A_MODE, md);
            apb(1'b1, A_SHIFT, {24'h0, tx});
            apb(1'b0, A_STAT, 32'h0);
            chk("active", rd, 32'h1);
            apb(1'b1, A_MODE, md);
            if (m == 2)
                repeat (8)
                begin
                    #62.5 slv_clk = 1'b0;
                    #62.5 slv_clk = 1'b1;
                end
            while (irq !== 1'b1) @(posedge core_clk);
            @(posedge core_clk);
            apb(1'b0, A_STAT, 32'h0);
            chk("done", rd, 32'h0);
            apb(1'b0, A_SHIFT, 32'h0);
            chk("received", rd, {24'h0, m == 1 ? rev8(peer_tx) : peer_tx});
            chk("sent", {24'h0, peer_rx}, {24'h0, m == 2 ? 8'h00 : m == 1 ? rev8(tx) : tx});
        end
        // Automatic mode, two bytes in one pass, launched by the trigger start bit.
        apb(1'b1, A_MODE, 32'hDC);
        apb(1'b1, A_CFG, 32'h1);
        apb(1'b1, A_TRIG, 32'h1);
        repeat (2)
        begin
            while (irq !== 1'b1) @(posedge core_clk);
            @(posedge core_clk);
        end
        apb(1'b0, A_TRIG, 32'h0);
        chk("request cleared", rd, 32'h0);
        apb(1'b0, A_CFG, 32'h0);
        chk("auto end", rd, 32'h00010001);
        chk("counter pin", {27'h0, adc}, 32'h1);
        apb(1'b1, A_MODE, 32'h0);
        apb(1'b0, A_SHIFT, 32'h0);
        chk("cleared", rd, 32'h0);
        chk("counter cleared", {27'h0, adc}, 32'h0);
        chk("ram gate", {31'h0, bae}, 32'h0);
        wrap_up;
    end
endmodule
